// File: logic/mac_phy_link.sv
// mac side of the internal phy link: gmii/mii framing, sideband status, management access
// Behaviour
// - gmii byte path at 1000 Mb/s, mii nibble path at 10/100, chosen by speed
// - half duplex only at 10/100; 1000 Mb/s always runs full duplex
// - mac and phy must agree on speed and duplex settings
// - all mac configuration goes through the control registers
// - management path is one data line plus clock, driven from registers
// - phy register reads and writes start by writing the management access register
// - phy reset combines host bus reset and the software phy reset bit
// - link indication drives link-up flag, a change event, and speed reload
// - after link restore take phy duplex into full-duplex flag unless forced
// - unforced speed shows, in the status speed field, the phy speed indication latched at the last link-up with auto-detect clear
// - mac drives its power state to the phy, with power management enable as a separate output
// - duplex is either forced by software or taken from negotiation
// - in full duplex transmit and receive run independently
// - transmit enable rises at frame start and holds while data is driven
// - half duplex collision: stop within four link clocks, jam, back off, retry
// - link counts as up only once software sets the set-link-up bit
// - with auto-detect and force-speed clear, reload speed on each link-up event
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/100ps
module mac_phy_link (
   // system
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        ce,
   // register port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic [31:0]      rdata,
   // transmit stream
   input  wire logic        tx_valid,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_last,
   output logic             tx_ready,
   output logic             tx_done,
   output logic             tx_retry,
   // receive stream
   output logic             rx_valid,
   output logic [7:0]       rx_data,
   output logic             rx_end,
   // gmii/mii link
   input  wire logic        link_tx_clk,
   input  wire logic        link_rx_clk,
   output logic [7:0]       link_txd,
   output logic             link_tx_en,
   input  wire logic [7:0]  link_rxd,
   input  wire logic        link_rx_dv,
   input  wire logic        link_col,
   input  wire logic        link_crs,
   // sideband
   input  wire logic        host_bus_reset_n,
   output logic             phy_reset,
   input  wire logic        phy_link_ind,
   input  wire logic        phy_full_duplex_ind,
   input  wire logic [1:0]  phy_speed_ind,
   output logic [1:0]       mac_power_state_ind,
   output logic             phy_pm_en,
   output logic             link_change,
   // management pins
   output logic             mdc,
   input  wire logic        mdio_i,
   output logic             mdio_o,
   output logic             mdio_oe_n
);
   typedef enum logic [2:0] {
      TX_IDLE    = 3'b000,
      TX_DEFER   = 3'b001,
      TX_DATA    = 3'b010,
      TX_IFG     = 3'b011,
      TX_JAM     = 3'b100,
      TX_BACKOFF = 3'b101
   } tx_state_t;

   localparam int SW = 18;

   logic [SW-1:0] sync1_reg;
   logic [SW-1:0] sync2_reg;
   logic          txc_d_reg;
   logic          rxc_d_reg;
   logic          tx_tick;
   logic          rx_tick;
   logic [7:0]    rxd_s;
   logic          rx_dv_s;
   logic          col_s;
   logic          crs_s;
   logic          host_rst_n_s;
   logic          link_s;
   logic          dpx_s;
   logic [1:0]    spd_s;

   logic [31:0]   ctrl_reg;
   logic          lchg_reg;
   logic          link_ok;
   logic          link_ok_d_reg;
   mac_link_pkg::speed_t speed_auto_reg;
   mac_link_pkg::speed_t speed_eff;
   logic          dpx_auto_reg;
   logic          full_dpx;
   logic          gmii;
   logic          phy_rst_active;

   tx_state_t     tx_state_reg;
   tx_state_t     tx_state_next;
   logic [15:0]   cnt_reg;
   logic          tx_nib_reg;
   logic [8:0]    lfsr_reg;
   logic [15:0]   ifg_ticks;
   logic [15:0]   jam_ticks;
   logic [15:0]   backoff_ticks;
   logic          half_col;
   logic          rx_nib_reg;
   logic          rx_act_reg;
   logic [3:0]    rx_lo_reg;

   logic          mg_start;
   logic [1:0]    mg_op_reg;
   logic [4:0]    mg_phy_reg;
   logic [4:0]    mg_regad_reg;
   logic          mg_busy;
   logic          mg_done;
   logic [15:0]   mg_rdata;
   logic          mg_ready_reg;

   // all pin-side levels except mdio share one two-stage synchroniser; the link clock is far slower
   // than clk, so data sampled at the detected clock edge has long settled
   always_ff @(posedge clk) begin
      if (reset) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         txc_d_reg <= 1'b0;
         rxc_d_reg <= 1'b0;
      end else if (ce) begin
         sync1_reg <= {link_tx_clk, link_rx_clk, link_rxd, link_rx_dv, link_col, link_crs,
                       host_bus_reset_n, phy_link_ind, phy_full_duplex_ind, phy_speed_ind};
         sync2_reg <= sync1_reg;
         txc_d_reg <= sync2_reg[17];
         rxc_d_reg <= sync2_reg[16];
      end
   end

   assign tx_tick      = sync2_reg[17] & ~txc_d_reg;
   assign rx_tick      = sync2_reg[16] & ~rxc_d_reg;
   assign rxd_s        = sync2_reg[15:8];
   assign rx_dv_s      = sync2_reg[7];
   assign col_s        = sync2_reg[6];
   assign crs_s        = sync2_reg[5];
   assign host_rst_n_s = sync2_reg[4];
   assign link_s       = sync2_reg[3];
   assign dpx_s        = sync2_reg[2];
   assign spd_s        = sync2_reg[1:0];

   // control register and sideband drive
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_reg <= mac_link_pkg::CTRL_RESET;
      end else if (ce && wr_en && addr == mac_link_pkg::CTRL_OFF) begin
         ctrl_reg <= wdata & mac_link_pkg::CTRL_WR_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         phy_reset           <= 1'b1;
         mac_power_state_ind <= 2'b00;
         phy_pm_en           <= 1'b0;
      end else if (ce) begin
         phy_reset           <= ~host_rst_n_s | ctrl_reg[mac_link_pkg::CTRL_PHYRST_POS];
         mac_power_state_ind <= ctrl_reg[mac_link_pkg::CTRL_PWR_POS +: 2];
         phy_pm_en           <= ctrl_reg[mac_link_pkg::CTRL_PMEN_POS];
      end
   end

   assign phy_rst_active = phy_reset;
   // the phy may force its link indication on; we take it as given
   assign link_ok = ctrl_reg[mac_link_pkg::CTRL_LINKUP_POS] & link_s & ~phy_rst_active;

   // link-up edge reloads duplex from the phy, and speed when auto-detect and force-speed are clear
   always_ff @(posedge clk) begin
      if (reset) begin
         link_ok_d_reg  <= 1'b0;
         speed_auto_reg <= mac_link_pkg::SPEED_10;
         dpx_auto_reg   <= 1'b0;
         link_change    <= 1'b0;
      end else if (ce) begin
         link_ok_d_reg <= link_ok;
         link_change   <= link_ok ^ link_ok_d_reg;
         if (link_ok && !link_ok_d_reg) begin
            dpx_auto_reg <= dpx_s;
            if (!ctrl_reg[mac_link_pkg::CTRL_AUTOSPD_POS] && !ctrl_reg[mac_link_pkg::CTRL_FORCESPD_POS])
               speed_auto_reg <= mac_link_pkg::speed_t'(spd_s);
         end
      end
   end

   // a change event sticks until software writes one to it; a new event wins over the clear
   always_ff @(posedge clk) begin
      if (reset) begin
         lchg_reg <= 1'b0;
      end else if (ce) begin
         if (link_ok ^ link_ok_d_reg)
            lchg_reg <= 1'b1;
         else if (wr_en && addr == mac_link_pkg::STATUS_OFF && wdata[mac_link_pkg::STAT_LCHG_POS])
            lchg_reg <= 1'b0;
      end
   end

   assign speed_eff = ctrl_reg[mac_link_pkg::CTRL_FORCESPD_POS] ?
                      mac_link_pkg::speed_t'(ctrl_reg[mac_link_pkg::CTRL_SPEED_POS +: 2]) :
                      speed_auto_reg;
   assign gmii      = (speed_eff == mac_link_pkg::SPEED_1000);
   assign full_dpx  = gmii | (ctrl_reg[mac_link_pkg::CTRL_FRC_DPX] ?
                      ctrl_reg[mac_link_pkg::CTRL_DPX_VAL_POS] : dpx_auto_reg);

   // transmit timing, in link clock ticks: one per byte on gmii, two on mii
   assign ifg_ticks     = gmii ? 16'(mac_link_pkg::IFG_BYTES) : 16'(2 * mac_link_pkg::IFG_BYTES);
   assign jam_ticks     = gmii ? 16'(mac_link_pkg::JAM_BYTES) : 16'(2 * mac_link_pkg::JAM_BYTES);
   assign backoff_ticks = 16'({lfsr_reg[2:0], {mac_link_pkg::SLOT_BYTES_LOG2{1'b0}}} << (gmii ? 0 : 1));
   assign half_col      = ~full_dpx & col_s;
   assign tx_ready      = ce & (tx_state_reg == TX_DATA) & tx_tick & tx_valid & ~half_col & (gmii | tx_nib_reg);

   always_comb begin
      tx_state_next = tx_state_reg;
      case (tx_state_reg)
         TX_IDLE: begin
            if (tx_valid && link_ok)
               tx_state_next = TX_DEFER;
         end
         TX_DEFER: begin
            if (tx_tick && !(~full_dpx & crs_s) && cnt_reg + 16'h1 >= ifg_ticks)
               tx_state_next = TX_DATA;
         end
         TX_DATA: begin
            if (half_col)
               tx_state_next = TX_JAM;
            else if (tx_tick && (!tx_valid || (tx_ready && tx_last)))
               tx_state_next = TX_IFG;
         end
         TX_IFG: begin
            if (tx_tick && cnt_reg + 16'h1 >= ifg_ticks)
               tx_state_next = TX_IDLE;
         end
         TX_JAM: begin
            if (tx_tick && cnt_reg + 16'h1 >= jam_ticks)
               tx_state_next = TX_BACKOFF;
         end
         TX_BACKOFF: begin
            if (tx_tick && cnt_reg == 16'h0)
               tx_state_next = TX_IDLE;
         end
         default: tx_state_next = TX_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset)
         tx_state_reg <= TX_IDLE;
      else if (ce)
         tx_state_reg <= tx_state_next;
   end

   // tick counter shared by defer, gap, jam and back-off
   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_reg <= 16'h0;
      end else if (ce) begin
         if (tx_state_next != tx_state_reg)
            cnt_reg <= (tx_state_next == TX_BACKOFF) ? backoff_ticks : 16'h0;
         else if (tx_tick && tx_state_reg == TX_BACKOFF)
            cnt_reg <= cnt_reg - 16'h1;
         else if (tx_tick && tx_state_reg == TX_DEFER && ~full_dpx && crs_s)
            cnt_reg <= 16'h0;
         else if (tx_tick)
            cnt_reg <= cnt_reg + 16'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset)
         lfsr_reg <= mac_link_pkg::LFSR_SEED;
      else if (ce)
         lfsr_reg <= {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[4]};
   end

   // link-side outputs change only on a link clock tick
   always_ff @(posedge clk) begin
      if (reset) begin
         link_tx_en <= 1'b0;
         link_txd   <= 8'h00;
         tx_nib_reg <= 1'b0;
      end else if (ce && tx_tick) begin
         if (tx_state_reg == TX_DATA && tx_valid && !half_col) begin
            link_tx_en <= 1'b1;
            tx_nib_reg <= ~gmii & ~tx_nib_reg;
            link_txd   <= gmii ? tx_data : (tx_nib_reg ? {4'h0, tx_data[7:4]} : {4'h0, tx_data[3:0]});
         end else if (tx_state_reg == TX_JAM) begin
            link_tx_en <= 1'b1;
            link_txd   <= gmii ? mac_link_pkg::JAM_PATTERN : {4'h0, mac_link_pkg::JAM_PATTERN[3:0]};
         end else begin
            link_tx_en <= 1'b0;
            link_txd   <= 8'h00;
            tx_nib_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tx_done  <= 1'b0;
         tx_retry <= 1'b0;
      end else if (ce) begin
         tx_done  <= tx_ready & tx_last;
         tx_retry <= (tx_state_reg == TX_BACKOFF) & (tx_state_next == TX_IDLE);
      end
   end

   // receive runs on its own clock ticks, untouched by the transmit state
   always_ff @(posedge clk) begin
      if (reset) begin
         rx_valid   <= 1'b0;
         rx_end     <= 1'b0;
         rx_data    <= 8'h00;
         rx_nib_reg <= 1'b0;
         rx_act_reg <= 1'b0;
         rx_lo_reg  <= 4'h0;
      end else if (ce) begin
         rx_valid <= 1'b0;
         rx_end   <= 1'b0;
         if (rx_tick) begin
            if (rx_dv_s) begin
               rx_act_reg <= 1'b1;
               if (gmii) begin
                  rx_data  <= rxd_s;
                  rx_valid <= 1'b1;
               end else if (rx_nib_reg) begin
                  rx_data    <= {rxd_s[3:0], rx_lo_reg};
                  rx_valid   <= 1'b1;
                  rx_nib_reg <= 1'b0;
               end else begin
                  rx_lo_reg  <= rxd_s[3:0];
                  rx_nib_reg <= 1'b1;
               end
            end else begin
               rx_end     <= rx_act_reg;
               rx_act_reg <= 1'b0;
               rx_nib_reg <= 1'b0;
            end
         end
      end
   end

   // management access register
   assign mg_start = ce & wr_en & (addr == mac_link_pkg::MGMT_OFF) & ~mg_busy;

   always_ff @(posedge clk) begin
      if (reset) begin
         mg_op_reg    <= 2'b00;
         mg_phy_reg   <= 5'h00;
         mg_regad_reg <= 5'h00;
         mg_ready_reg <= 1'b0;
      end else if (ce) begin
         if (mg_start) begin
            mg_op_reg    <= wdata[mac_link_pkg::MGMT_OP_POS +: 2];
            mg_phy_reg   <= wdata[mac_link_pkg::MGMT_PHY_POS +: 5];
            mg_regad_reg <= wdata[mac_link_pkg::MGMT_REG_POS +: 5];
            mg_ready_reg <= 1'b0;
         end else if (mg_done) begin
            mg_ready_reg <= 1'b1;
         end
      end
   end

   mgmt_serial_engine u_mgmt (
      .clk       (clk),
      .reset     (reset),
      .ce        (ce),
      .start     (mg_start),
      .op        (wdata[mac_link_pkg::MGMT_OP_POS +: 2]),
      .phy_addr  (wdata[mac_link_pkg::MGMT_PHY_POS +: 5]),
      .reg_addr  (wdata[mac_link_pkg::MGMT_REG_POS +: 5]),
      .wdata     (wdata[15:0]),
      .busy      (mg_busy),
      .done      (mg_done),
      .rdata     (mg_rdata),
      .mdc       (mdc),
      .mdio_i    (mdio_i),
      .mdio_o    (mdio_o),
      .mdio_oe_n (mdio_oe_n)
   );

   // register read port: data in the cycle after the strobe, unmapped reads as zero
   always_ff @(posedge clk) begin
      if (reset) begin
         rdata <= 32'h0;
      end else if (ce) begin
         rdata <= 32'h0;
         if (rd_en) begin
            case (addr)
               mac_link_pkg::CTRL_OFF: rdata <= ctrl_reg;
               mac_link_pkg::STATUS_OFF: begin
                  rdata[mac_link_pkg::STAT_DPX_POS]        <= full_dpx;
                  rdata[mac_link_pkg::STAT_LINKUP_POS]     <= link_ok;
                  rdata[mac_link_pkg::STAT_SPEED_POS +: 2] <= speed_eff;
                  rdata[mac_link_pkg::STAT_PHYRST_POS]     <= phy_rst_active;
                  rdata[mac_link_pkg::STAT_TXBUSY_POS]     <= (tx_state_reg != TX_IDLE);
                  rdata[mac_link_pkg::STAT_LCHG_POS]       <= lchg_reg;
               end
               mac_link_pkg::MGMT_OFF: begin
                  rdata[15:0]                              <= mg_rdata;
                  rdata[mac_link_pkg::MGMT_REG_POS +: 5]   <= mg_regad_reg;
                  rdata[mac_link_pkg::MGMT_PHY_POS +: 5]   <= mg_phy_reg;
                  rdata[mac_link_pkg::MGMT_OP_POS +: 2]    <= mg_op_reg;
                  rdata[mac_link_pkg::MGMT_READY_POS]      <= mg_ready_reg;
               end
               default: rdata <= 32'h0;
            endcase
         end
      end
   end
endmodule

// File: logic/mac_link_pkg.sv
// shared constants for the mac-side phy link block
package mac_link_pkg;
   // timing
   localparam int CLK_PERIOD_NS     = 20;
   localparam int MDC_MIN_PERIOD_NS = 400;
   localparam int MDC_HALF_CYCLES   = (MDC_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int IFG_BYTES         = 12;
   localparam int JAM_BYTES         = 4;
   localparam int SLOT_BYTES_LOG2   = 6;
   // register offsets
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] STATUS_OFF = 8'h08;
   localparam logic [7:0] MGMT_OFF   = 8'h20;
   // control fields
   localparam int CTRL_DPX_VAL_POS  = 0;
   localparam int CTRL_FRC_DPX      = 1;
   localparam int CTRL_LINKUP_POS   = 2;
   localparam int CTRL_AUTOSPD_POS  = 3;
   localparam int CTRL_FORCESPD_POS = 4;
   localparam int CTRL_SPEED_POS    = 5;
   localparam int CTRL_PHYRST_POS   = 7;
   localparam int CTRL_PMEN_POS     = 8;
   localparam int CTRL_PWR_POS      = 9;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   localparam logic [31:0] CTRL_WR_MASK = 32'h0000_07ff;
   // status fields
   localparam int STAT_DPX_POS    = 0;
   localparam int STAT_LINKUP_POS = 1;
   localparam int STAT_SPEED_POS  = 2;
   localparam int STAT_PHYRST_POS = 4;
   localparam int STAT_TXBUSY_POS = 5;
   localparam int STAT_LCHG_POS   = 6;
   // management access fields
   localparam int MGMT_REG_POS   = 16;
   localparam int MGMT_PHY_POS   = 21;
   localparam int MGMT_OP_POS    = 26;
   localparam int MGMT_READY_POS = 28;
   localparam logic [1:0] MGMT_OP_WRITE = 2'h1;
   localparam logic [1:0] MGMT_OP_READ  = 2'h2;
   localparam logic [1:0] MGMT_START    = 2'h1;
   localparam logic [31:0] MGMT_PREAMBLE = 32'hffff_ffff;
   localparam int MGMT_FRAME_BITS = 64;
   localparam int MGMT_TA_BIT     = 46;
   localparam int MGMT_DATA_BIT   = 48;
   // link values
   localparam logic [7:0] JAM_PATTERN = 8'h55;
   localparam logic [8:0] LFSR_SEED   = 9'h1a5;
   typedef enum logic [1:0] {
      SPEED_10   = 2'b00,
      SPEED_100  = 2'b01,
      SPEED_1000 = 2'b10
   } speed_t;
endpackage

// File: logic/mgmt_serial_engine.sv
// serial management frame engine: clock divider, frame shifter, read capture
`timescale 1ns/100ps
module mgmt_serial_engine (
   // system
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        ce,
   // request
   input  wire logic        start,
   input  wire logic [1:0]  op,
   input  wire logic [4:0]  phy_addr,
   input  wire logic [4:0]  reg_addr,
   input  wire logic [15:0] wdata,
   output logic             busy,
   output logic             done,
   output logic [15:0]      rdata,
   // management pins
   output logic             mdc,
   input  wire logic        mdio_i,
   output logic             mdio_o,
   output logic             mdio_oe_n
);
   logic [63:0] shift_reg;
   logic [6:0]  bit_reg;
   logic [7:0]  div_reg;
   logic        rd_reg;
   logic        mdio_s1;
   logic        mdio_s2;
   logic        half_end;

   assign half_end  = (div_reg == 8'(mac_link_pkg::MDC_HALF_CYCLES - 1));
   assign mdio_o    = shift_reg[63];
   // release the line from turnaround onward in a read
   assign mdio_oe_n = ~(busy && (!rd_reg || bit_reg < 7'(mac_link_pkg::MGMT_TA_BIT)));

   always_ff @(posedge clk) begin
      if (reset) begin
         mdio_s1 <= 1'b1;
         mdio_s2 <= 1'b1;
      end else if (ce) begin
         mdio_s1 <= mdio_i;
         mdio_s2 <= mdio_s1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         busy      <= 1'b0;
         done      <= 1'b0;
         mdc       <= 1'b0;
         div_reg   <= 8'h00;
         bit_reg   <= 7'h00;
         rd_reg    <= 1'b0;
         shift_reg <= 64'h0;
         rdata     <= 16'h0000;
      end else if (ce) begin
         done <= 1'b0;
         if (!busy) begin
            if (start) begin
               busy      <= 1'b1;
               mdc       <= 1'b0;
               div_reg   <= 8'h00;
               bit_reg   <= 7'h00;
               rd_reg    <= (op == mac_link_pkg::MGMT_OP_READ);
               shift_reg <= {mac_link_pkg::MGMT_PREAMBLE, mac_link_pkg::MGMT_START, op, phy_addr, reg_addr,
                             (op == mac_link_pkg::MGMT_OP_READ) ? 2'h3 : 2'h2, wdata};
            end
         end else if (half_end) begin
            div_reg <= 8'h00;
            mdc     <= ~mdc;
            if (!mdc) begin
               // the phy samples on the rising edge, so read data is taken there too
               if (rd_reg && bit_reg >= 7'(mac_link_pkg::MGMT_DATA_BIT))
                  rdata <= {rdata[14:0], mdio_s2};
            end else begin
               shift_reg <= {shift_reg[62:0], 1'b1};
               bit_reg   <= bit_reg + 7'h01;
               if (bit_reg == 7'(mac_link_pkg::MGMT_FRAME_BITS - 1)) begin
                  busy <= 1'b0;
                  done <= 1'b1;
               end
            end
         end else begin
            div_reg <= div_reg + 8'h01;
         end
      end
   end
endmodule

// File: tb/mac_link_assertions.sv
// port-level checks for the mac side phy link block
`timescale 1ns/100ps
module mac_link_checker (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        ce,
   input wire logic [7:0]  addr,
   input wire logic [31:0] wdata,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [31:0] rdata,
   input wire logic        tx_last,
   input wire logic        tx_ready,
   input wire logic        tx_done,
   input wire logic        link_tx_en,
   input wire logic        host_bus_reset_n,
   input wire logic        phy_reset,
   input wire logic [1:0]  mac_power_state_ind,
   input wire logic        phy_pm_en,
   input wire logic        mdc
);
   logic       pm_exp;
   logic [1:0] pw_exp;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   always_ff @(posedge clk) begin
      if (wr_en && ce && addr == mac_link_pkg::CTRL_OFF) begin
         pm_exp <= wdata[8];
         pw_exp <= wdata[10:9];
      end
   end
   a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 32'h0)
      else $error("read data outside its slot");
   a_host_phy_rst: assert property (!host_bus_reset_n |-> ##[0:4] phy_reset)
      else $error("host reset not passed to phy");
   a_soft_phy_rst: assert property (wr_en && ce && addr == 8'h00 && wdata[7] |-> ##[1:4] phy_reset)
      else $error("soft reset bit not passed to phy");
   a_power_state: assert property (wr_en && ce && addr == 8'h00 |->
      ##2 phy_pm_en == pm_exp && mac_power_state_ind == pw_exp)
      else $error("power state not shown to phy");
   a_tx_en_hold: assert property (tx_ready |=> link_tx_en)
      else $error("byte taken without transmit enable");
   a_tx_done_end: assert property (tx_ready && tx_last |=> tx_done)
      else $error("no done after last byte");
   a_rst_no_tx: assert property (phy_reset |-> !tx_ready)
      else $error("byte taken while phy in reset");
   a_mdc_high: assert property ($rose(mdc) |-> mdc [*8])
      else $error("management clock high phase too short");
endmodule
bind mac_phy_link mac_link_checker checker_i (.*);

// File: tb/phy_model.sv
// behavioural copper phy: link clocks, sideband indications, receive bytes, pulled-up mdio
`timescale 1ns/100ps
module phy_model (
   // bench control
   input  wire logic       link_on,
   input  wire logic       dpx,
   input  wire logic [1:0] spd,
   input  wire logic       rx_go,
   input  wire logic [7:0] rx_byte,
   // mac side
   output logic            link_tx_clk,
   output logic            link_rx_clk,
   output logic [7:0]      link_rxd,
   output logic            link_rx_dv,
   output logic            link_col,
   output logic            link_crs,
   output logic            phy_link_ind,
   output logic            phy_full_duplex_ind,
   output logic [1:0]      phy_speed_ind,
   input  wire logic       mdio_o,
   input  wire logic       mdio_oe_n,
   output logic            mdio_i
);
   initial begin
      {link_rx_dv, link_rxd, link_tx_clk} = '0;
      #7;
      forever #80 link_tx_clk = ~link_tx_clk;
   end
   // data move on the falling edge so the mac samples them settled
   always @(negedge link_tx_clk) begin
      link_rx_dv <= rx_go;
      link_rxd <= rx_go ? rx_byte : ~link_rxd;
   end
   assign link_rx_clk = link_tx_clk;
   assign link_col = 1'b0;
   assign link_crs = link_rx_dv;
   assign phy_link_ind = link_on;
   assign phy_full_duplex_ind = dpx;
   assign phy_speed_ind = spd;
   assign mdio_i = mdio_oe_n ? 1'b1 : mdio_o;
endmodule

// File: tb/mac_phy_link_test.sv
// bench for the mac side phy link block
`timescale 1ns/100ps
module mac_phy_link_test;
   logic clk, reset, ce, wr_en, rd_en, tx_valid, tx_last, host_bus_reset_n, link_on, dpx, rx_go, drove, chg_seen;
   logic tx_ready, tx_done, tx_retry, rx_valid, rx_end, link_tx_en, phy_reset, phy_pm_en, link_change;
   logic mdc, mdio_i, mdio_o, mdio_oe_n, link_tx_clk, link_rx_clk, link_rx_dv, link_col, link_crs;
   logic phy_link_ind, phy_full_duplex_ind;
   logic [1:0] spd, phy_speed_ind, mac_power_state_ind;
   logic [2:0] ev;
   logic [7:0] addr, tx_data, rx_byte, rx_data, link_txd, link_rxd;
   logic [31:0] wdata, rdata, v;
   logic [1:0] sp[3] = '{2'h1, 2'h0, 2'h2};
   logic [31:0] ex[3] = '{32'h46, 32'h43, 32'h4b};
   int fails, total_checks;
   mac_phy_link mac_phy_link_i (.*);
   phy_model phy_model_i (.*);
   assign ev = {rx_end, rx_valid, tx_ready};
   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) if (mdio_oe_n === 1'b0) drove <= 1'b1;
   always @(posedge clk) if (link_change === 1'b1) chg_seen <= 1'b1;
   task automatic chk(input string n, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic waitev(input int k);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (ev[k] !== 1'b1 && n < 4000);
      chk("event", ev[k], 1'b1);
   endtask
   task automatic relink(input logic [1:0] s, input logic f);
      link_on <= 1'b0;
      cyc(10);
      spd <= s;
      dpx <= f;
      link_on <= 1'b1;
      cyc(10);
   endtask
   task automatic send(input logic [7:0] b, input logic l, m);
      tx_data <= b;
      tx_last <= l;
      tx_valid <= 1'b1;
      waitev(0);
      @(posedge clk);
      if (l) tx_valid <= 1'b0;
      #1 chk("txd", link_txd, m ? {4'h0, b[7:4]} : b);
      chk("tx_en", link_tx_en, 1'b1);
      if (l) chk("tx_done", tx_done, 1'b1);
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      {ce, host_bus_reset_n, reset} = 3'h7;
      {wr_en, rd_en, tx_valid, tx_last, link_on, dpx, rx_go, drove, chg_seen, addr, tx_data, rx_byte, wdata, spd} = '0;
      {fails, total_checks} = '0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      #1 chk("phy_reset", phy_reset, 1'b1);
      wr(8'h44, 32'hffff_ffff);
      rd(8'h44);
      chk("unmapped", v, 32'h0);
      wr(mac_link_pkg::CTRL_OFF, 32'hffff_f784);
      rd(mac_link_pkg::CTRL_OFF);
      chk("ctrl", v, 32'h784);
      link_on <= 1'b1;
      cyc(10);
      chk("pm_en", phy_pm_en, 1'b1);
      chk("pwr", mac_power_state_ind, 2'h3);
      chk("phy_reset", phy_reset, 1'b1);
      rd(mac_link_pkg::STATUS_OFF);
      chk("lu_in_reset", v[1], 1'b0);
      wr(mac_link_pkg::CTRL_OFF, 32'h0);
      cyc(10);
      chk("phy_reset", phy_reset, 1'b0);
      rd(mac_link_pkg::STATUS_OFF);
      chk("lu_no_slu", v[1], 1'b0);
      host_bus_reset_n <= 1'b0;
      cyc(6);
      chk("phy_reset", phy_reset, 1'b1);
      host_bus_reset_n <= 1'b1;
      cyc(6);
      $display("test sideband done");
      wr(mac_link_pkg::CTRL_OFF, 32'h4);
      for (int i = 0; i < 3; i++) begin
         relink(sp[i], i == 1);
         rd(mac_link_pkg::STATUS_OFF);
         chk("status", v & 32'h4f, ex[i]);
         wr(mac_link_pkg::STATUS_OFF, 32'h40);
      end
      chk("link_change", chg_seen, 1'b1);
      $display("test status done");
      rx_byte <= 8'ha6;
      rx_go <= 1'b1;
      waitev(1);
      chk("rx_data", rx_data, 8'ha6);
      @(posedge clk);
      rx_go <= 1'b0;
      waitev(2);
      chk("rx_end", rx_end, 1'b1);
      for (int m = 0; m < 2; m++) begin
         if (m == 1) relink(2'h1, 1'b1);
         send(8'h3c, 1'b0, m[0]);
         send(8'hd2, 1'b1, m[0]);
      end
      $display("test stream done");
      wr(mac_link_pkg::MGMT_OFF, 32'h0822_0000);
      for (int i = 0; i < 3000 && v[28] !== 1'b1; i++) rd(mac_link_pkg::MGMT_OFF);
      chk("mgmt_ready", v[28], 1'b1);
      chk("mgmt_data", v[15:0], 16'hffff);
      chk("mdio_drove", drove, 1'b1);
      $display("test management done");
      close_out;
   end
   initial begin
      #1_000_000;
      fails++;
      close_out;
   end
endmodule
